// ### rtl/lvd_ctrl.sv
`timescale 1ns/10ps
`default_nettype none

module lvd_ctrl
   import lvd_pkg::*;
(
   // Clock and system reset (any reset other than this block's own)
   input  wire logic                 core_clk_i,
   input  wire logic                 rst_i,
   // Wishbone classic slave
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   input  wire logic                 wb_we_i,
   input  wire logic [LVD_ADR_W-1:0] wb_adr_i,
   input  wire logic [LVD_SEL_W-1:0] wb_sel_i,
   input  wire logic [LVD_DAT_W-1:0] wb_dat_i,
   output logic      [LVD_DAT_W-1:0] wb_dat_o,
   output logic                      wb_ack_o,
   // Asynchronous comparator results, high while below level
   input  wire logic                 supply_below_i,
   input  wire logic                 ext_below_i,
   // Analog control
   output logic                      detector_enable_o,
   output logic                      source_select_o,
   output logic [LVD_LEVEL_W-1:0]    level_code_o,
   // Reset and interrupt towards the core
   output logic                      lv_reset_o,
   output logic                      low_voltage_irq_o,
   output logic                      detect_irq_request_o,
   output logic                      detect_irq_mask_o
);

   // Control state
   logic                   enable_q;
   logic                   mode_q;
   logic                   source_q;
   logic [LVD_LEVEL_W-1:0] level_q;
   logic                   irq_req_q;
   logic                   irq_req_d;
   logic                   mask_q;
   logic                   mask_d;
   logic                   cause_q;
   logic                   cause_d;
   // Detection state
   logic                   below_prev_q;
   logic                   lv_reset_q;
   logic                   irq_pulse_q;
   // Bus state
   logic                   ack_q;
   logic [LVD_DAT_W-1:0]   rdata_q;

   // Byte lane 0 write decode for one register offset
   function automatic logic lane0_hit(
      input logic [LVD_ADR_W-1:0] adr,
      input logic [3:0]           ofs,
      input logic [LVD_SEL_W-1:0] sel
   );
      lane0_hit = (adr[3:2] == ofs[3:2]) && sel[0];
   endfunction

   // Synchronised comparator levels
   logic supply_below_s;
   logic ext_below_s;

   lvd_sync2 #(
      .WIDTH (2)
   ) u_sync (
      .core_clk_i (core_clk_i),
      .rst_i      (rst_i),
      .async_i    ({supply_below_i, ext_below_i}),
      .sync_o     ({supply_below_s, ext_below_s})
   );

   // Selected comparison, forced to above-level while disabled
   wire  src_below   = (source_q == LVD_SRC_EXTERNAL) ?
                       ext_below_s : supply_below_s;
   wire  below_level = enable_q & src_below;

   // Bus request decode; the write lands on the edge that sees ack
   wire  bus_req     = wb_cyc_i & wb_stb_i;
   wire  bus_commit  = bus_req & ack_q;
   wire  wr_commit   = bus_commit & wb_we_i;
   wire  rd_commit   = bus_commit & ~wb_we_i;
   wire  wr_ctrl     = wr_commit & lane0_hit(wb_adr_i, LVD_OFS_CTRL,
                                             wb_sel_i);
   wire  wr_level    = wr_commit & lane0_hit(wb_adr_i, LVD_OFS_LEVEL,
                                             wb_sel_i);
   wire  wr_irq      = wr_commit & lane0_hit(wb_adr_i, LVD_OFS_IRQ,
                                             wb_sel_i);
   wire  rd_cause    = rd_commit &
                       (wb_adr_i[3:2] == LVD_OFS_CAUSE[3:2]);

   // Crossing event: any change of the selected result, including the
   // drop to above-level when enable is cleared while below
   wire  crossing    = below_level ^ below_prev_q;
   wire  irq_event   = crossing & ~mode_q & ~lv_reset_q;

   // Reset request: level driven, so setting the mode while above
   // level produces nothing
   wire  lv_reset_d  = below_level & mode_q;

   // Interrupt request flag: a crossing outranks a software clear
   always_comb begin
      irq_req_d = irq_req_q;
      if (wr_irq) begin
         irq_req_d = wb_dat_i[LVD_IRQ_REQ];
      end
      if (irq_event) begin
         irq_req_d = 1'b1;
      end
   end

   // Mask: software owns it, but a detector reset forces it on
   always_comb begin
      mask_d = mask_q;
      if (wr_irq) begin
         mask_d = wb_dat_i[LVD_IRQ_MASK];
      end
      if (lv_reset_q) begin
         mask_d = LVD_MASK_RST;
      end
   end

   // Reset cause: cleared by reading it, a new cause wins over the read
   always_comb begin
      cause_d = cause_q;
      if (rd_cause) begin
         cause_d = 1'b0;
      end
      if (lv_reset_q) begin
         cause_d = 1'b1;
      end
   end

   // Read data mux, zero for unmapped offsets
   logic [LVD_DAT_W-1:0] rdata_d;
   always_comb begin
      rdata_d = '0;
      case (wb_adr_i[3:2])
         LVD_OFS_CTRL[3:2]: begin
            rdata_d[LVD_CTRL_EN]   = enable_q;
            rdata_d[LVD_CTRL_SRC]  = source_q;
            rdata_d[LVD_CTRL_MODE] = mode_q;
            rdata_d[LVD_CTRL_FLAG] = below_level;
         end
         LVD_OFS_LEVEL[3:2]: begin
            rdata_d[LVD_LEVEL_W-1:0] = level_q;
         end
         LVD_OFS_IRQ[3:2]: begin
            rdata_d[LVD_IRQ_REQ]  = irq_req_q;
            rdata_d[LVD_IRQ_MASK] = mask_q;
         end
         LVD_OFS_CAUSE[3:2]: begin
            rdata_d[LVD_CAUSE_LV] = cause_q;
         end
         default: begin
            rdata_d = '0;
         end
      endcase
   end

   // Wishbone handshake: ack one cycle after the request, dropped after
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         ack_q   <= 1'b0;
         rdata_q <= '0;
      end else begin
         ack_q   <= bus_req & ~ack_q;
         rdata_q <= rdata_d;
      end
   end

   // Settings survive this block's own reset; only rst_i clears them
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         enable_q <= 1'b0;
         mode_q   <= 1'b0;
         source_q <= LVD_SRC_SUPPLY;
         level_q  <= LVD_LEVEL_RST;
      end else begin
         if (wr_ctrl) begin
            enable_q <= wb_dat_i[LVD_CTRL_EN];
            mode_q   <= wb_dat_i[LVD_CTRL_MODE];
            source_q <= wb_dat_i[LVD_CTRL_SRC];
         end
         if (wr_level) begin
            level_q  <= wb_dat_i[LVD_LEVEL_W-1:0];
         end
      end
   end

   // Interrupt flags and reset cause; a detector reset clears the
   // pending request the same way any core reset would
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         irq_req_q <= 1'b0;
         mask_q    <= LVD_MASK_RST;
         cause_q   <= 1'b0;
      end else begin
         irq_req_q <= irq_req_d & ~lv_reset_q;
         mask_q    <= mask_d;
         cause_q   <= cause_d;
      end
   end

   // Detection pipeline
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         below_prev_q <= 1'b0;
         lv_reset_q   <= 1'b0;
         irq_pulse_q  <= 1'b0;
      end else begin
         below_prev_q <= below_level;
         lv_reset_q   <= lv_reset_d;
         irq_pulse_q  <= irq_event;
      end
   end

   // Outputs
   assign wb_ack_o             = ack_q;
   assign wb_dat_o             = rdata_q;
   assign detector_enable_o    = enable_q;
   assign source_select_o      = source_q;
   assign level_code_o         = level_q;
   assign lv_reset_o           = lv_reset_q;
   assign low_voltage_irq_o    = irq_pulse_q;
   assign detect_irq_request_o = irq_req_q;
   assign detect_irq_mask_o    = mask_q;

endmodule

`default_nettype wire

// ### rtl/lvd_pkg.sv
// Shared constants for the low-voltage detect control block
package lvd_pkg;

   // Register bus geometry
   localparam int          LVD_ADR_W        = 4;
   localparam int          LVD_DAT_W        = 32;
   localparam int          LVD_SEL_W        = LVD_DAT_W / 8;

   // Register byte offsets
   localparam logic [3:0]  LVD_OFS_CTRL     = 4'h0;
   localparam logic [3:0]  LVD_OFS_LEVEL    = 4'h4;
   localparam logic [3:0]  LVD_OFS_IRQ      = 4'h8;
   localparam logic [3:0]  LVD_OFS_CAUSE    = 4'hc;

   // Control register bit positions
   localparam int          LVD_CTRL_FLAG    = 0;
   localparam int          LVD_CTRL_MODE    = 1;
   localparam int          LVD_CTRL_SRC     = 2;
   localparam int          LVD_CTRL_EN      = 7;

   // Interrupt register bit positions
   localparam int          LVD_IRQ_REQ      = 0;
   localparam int          LVD_IRQ_MASK     = 1;

   // Reset cause register bit position
   localparam int          LVD_CAUSE_LV     = 0;

   // Level code field width
   localparam int          LVD_LEVEL_W      = 4;

   // Reset values
   localparam logic [3:0]  LVD_LEVEL_RST    = 4'h0;
   localparam logic        LVD_MASK_RST     = 1'b1;

   // Comparator source encoding
   typedef enum logic {
      LVD_SRC_SUPPLY,
      LVD_SRC_EXTERNAL
   } lvd_src_e;

endpackage

// ### rtl/lvd_sync2.sv
`timescale 1ns/10ps
`default_nettype none

// Two-flop synchroniser for asynchronous levels
module lvd_sync2
   import lvd_pkg::*;
#(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input  wire logic             core_clk_i,
   input  wire logic             rst_i,
   // Asynchronous in, synchronous out
   input  wire logic [WIDTH-1:0] async_i,
   output logic      [WIDTH-1:0] sync_o
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   // First stage feeds only the second stage
   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_i;
         sync_q <= meta_q;
      end
   end

   assign sync_o = sync_q;

endmodule

`default_nettype wire

// ### verification/lvd_ctrl_assertions.sv
`timescale 1ns/10ps
`default_nettype none
// Port-level checks of the detect control block
module lvd_ctrl_assertions
   import lvd_pkg::*;
(
   // Clock, reset and bus handshake
   input wire logic                   core_clk_i,
   input wire logic                   rst_i,
   input wire logic                   wb_cyc_i,
   input wire logic                   wb_stb_i,
   input wire logic                   wb_ack_o,
   // Comparators and outputs
   input wire logic                   supply_below_i,
   input wire logic                   ext_below_i,
   input wire logic                   detector_enable_o,
   input wire logic                   source_select_o,
   input wire logic [LVD_LEVEL_W-1:0] level_code_o,
   input wire logic                   lv_reset_o,
   input wire logic                   low_voltage_irq_o,
   input wire logic                   detect_irq_request_o,
   input wire logic                   detect_irq_mask_o
);
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (rst_i);
   // Selected comparator before the synchroniser
   wire sel_below = source_select_o ? ext_below_i : supply_below_i;
   sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
   sequence s_ack; wb_ack_o ##1 !wb_ack_o; endsequence
   a_ack_one_pulse: assert property (s_req |=> s_ack)
      else $error("bus ack missing or longer than one cycle");
   a_irq_one_cycle: assert property (
      low_voltage_irq_o |=> !low_voltage_irq_o) else $error("irq too long");
   a_irq_sets_req: assert property (
      low_voltage_irq_o |-> detect_irq_request_o) else $error("no request");
   a_reset_cause: assert property (
      $rose(lv_reset_o) |-> $past(sel_below, 3)) else $error("bad reset");
   a_reset_release: assert property (
      lv_reset_o && !sel_below |-> ##[1:4] !lv_reset_o)
      else $error("reset not released");
   a_mask_on_reset: assert property (
      lv_reset_o |=> detect_irq_mask_o) else $error("mask not set");
   a_keep_on_reset: assert property (
      lv_reset_o |=> $stable(detector_enable_o) && $stable(source_select_o)
      && $stable(level_code_o)) else $error("settings lost in reset");
   a_no_irq_reset: assert property (
      lv_reset_o |-> !low_voltage_irq_o) else $error("irq during reset");
   a_reset_values: assert property (disable iff (1'b0)
      rst_i |=> !detector_enable_o && !source_select_o && !lv_reset_o
      && detect_irq_mask_o && level_code_o == LVD_LEVEL_RST)
      else $error("bad values after reset");
endmodule
bind lvd_ctrl lvd_ctrl_assertions u_chk (
   .core_clk_i(core_clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
   .supply_below_i(supply_below_i), .ext_below_i(ext_below_i),
   .detector_enable_o(detector_enable_o),
   .source_select_o(source_select_o), .level_code_o(level_code_o),
   .lv_reset_o(lv_reset_o), .low_voltage_irq_o(low_voltage_irq_o),
   .detect_irq_request_o(detect_irq_request_o),
   .detect_irq_mask_o(detect_irq_mask_o));
`default_nettype wire

// ### verification/lvd_comparator_model.sv
`timescale 1ns/10ps
`default_nettype none
// Stand-in for both analog comparators
module lvd_comparator_model
   import lvd_pkg::*;
(
   // Clock used to time level changes
   input  wire logic core_clk_i,
   // Results, high while below level
   output logic      supply_below_o,
   output logic      ext_below_o
);
   // Start at or above level so enabling raises no event
   initial begin
      supply_below_o = 1'b0;
      ext_below_o = 1'b0;
   end
   // Levels move just after an edge; the full sync latency still applies
   task automatic drive(input logic s, input logic e);
      @(posedge core_clk_i);
      supply_below_o <= s;
      ext_below_o <= e;
   endtask
endmodule
`default_nettype wire

// ### verification/tb_lvd_ctrl.sv
`timescale 1ns/10ps
`default_nettype none
// Self-checking bench for the detect control block
module tb_lvd_ctrl
   import lvd_pkg::*;
;
   localparam int SETTLE = 1250; // 10 us of comparator settling
   logic        clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we  = 1'b0;
   logic [3:0]  adr = 4'h0;
   logic [3:0]  sel = 4'h0;
   logic [31:0] dat = 32'h0;
   logic [31:0] rd;
   wire  [31:0] dat_o;
   wire  [3:0]  level;
   wire         ack, en, src, lvr, irq, req, mask, sup, ext;
   int          mismatches = 0;
   int          checks_done = 0;
   int          irqs = 0;
   always #4 clk = ~clk;
   // Count crossing pulses, each one cycle long
   always @(posedge clk) if (irq === 1'b1) irqs <= irqs + 1;
   lvd_comparator_model cmp (.core_clk_i(clk), .supply_below_o(sup),
      .ext_below_o(ext));
   lvd_ctrl DUT (.core_clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
      .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
      .supply_below_i(sup), .ext_below_i(ext), .detector_enable_o(en),
      .source_select_o(src), .level_code_o(level), .lv_reset_o(lvr),
      .low_voltage_irq_o(irq), .detect_irq_request_o(req),
      .detect_irq_mask_o(mask));
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp) begin
         mismatches++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // One classic cycle; the request holds until ack is sampled
   task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      dat <= {24'h0, d};
      sel <= 4'hf;
      do @(posedge clk); while (ack !== 1'b1);
      rd = dat_o;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask
   task automatic rdchk(input logic [3:0] a, input logic [7:0] e);
      bus(1'b0, a, 8'h00);
      chk(rd, {24'h0, e});
   endtask
   task automatic t_defaults;
      rdchk(LVD_OFS_CTRL, 8'h00);
      rdchk(LVD_OFS_LEVEL, 8'h00);
      rdchk(LVD_OFS_IRQ, 8'h02);
   endtask
   task automatic t_irq_supply;
      int n0;
      n0 = irqs;
      bus(1'b1, LVD_OFS_IRQ, 8'h02);
      bus(1'b1, LVD_OFS_LEVEL, 8'h0f);
      bus(1'b1, LVD_OFS_CTRL, 8'h80);
      chk({28'h0, level}, 32'hf);
      repeat (SETTLE) @(posedge clk);
      rdchk(LVD_OFS_CTRL, 8'h80);
      chk({31'h0, en}, 32'h1);
      bus(1'b1, LVD_OFS_IRQ, 8'h00);
      cmp.drive(1'b1, 1'b0);
      repeat (4) @(posedge clk);
      rdchk(LVD_OFS_CTRL, 8'h81);
      chk({31'h0, req}, 32'h1);
      rdchk(LVD_OFS_IRQ, 8'h01);
      cmp.drive(1'b0, 1'b0);
      // The pulse counter updates on the fourth edge, so look one later
      repeat (5) @(posedge clk);
      chk(irqs, n0 + 2);
      cmp.drive(1'b1, 1'b0);
      repeat (4) @(posedge clk);
      bus(1'b1, LVD_OFS_IRQ, 8'h00);
      bus(1'b1, LVD_OFS_CTRL, 8'h00);
      repeat (4) @(posedge clk);
      chk(irqs, n0 + 4);
      rdchk(LVD_OFS_IRQ, 8'h01);
      cmp.drive(1'b0, 1'b0);
   endtask
   task automatic t_irq_ext;
      int n0;
      n0 = irqs;
      bus(1'b1, LVD_OFS_IRQ, 8'h02);
      bus(1'b1, LVD_OFS_CTRL, 8'h84);
      repeat (SETTLE) @(posedge clk);
      chk({31'h0, src}, 32'h1);
      cmp.drive(1'b1, 1'b0);
      repeat (4) @(posedge clk);
      cmp.drive(1'b1, 1'b1);
      repeat (4) @(posedge clk);
      cmp.drive(1'b0, 1'b0);
      repeat (5) @(posedge clk);
      chk(irqs, n0 + 2);
      bus(1'b1, LVD_OFS_CTRL, 8'h00);
   endtask
   // Reset mode on either source
   task automatic t_reset(input logic s);
      bus(1'b1, LVD_OFS_IRQ, 8'h02);
      bus(1'b1, LVD_OFS_CTRL, {1'b1, 4'h0, s, 2'b00});
      repeat (SETTLE) @(posedge clk);
      rdchk(LVD_OFS_CTRL, {1'b1, 4'h0, s, 2'b00});
      bus(1'b1, LVD_OFS_CTRL, {1'b1, 4'h0, s, 2'b10});
      repeat (4) @(posedge clk);
      chk({31'h0, lvr}, 32'h0);
      cmp.drive(~s, s);
      repeat (4) @(posedge clk);
      chk({31'h0, lvr}, 32'h1);
      rdchk(LVD_OFS_CTRL, {1'b1, 4'h0, s, 2'b11});
      rdchk(LVD_OFS_IRQ, 8'h02);
      chk({31'h0, mask}, 32'h1);
      rdchk(LVD_OFS_LEVEL, 8'h0f);
      cmp.drive(1'b0, 1'b0);
      repeat (4) @(posedge clk);
      chk({31'h0, lvr}, 32'h0);
      rdchk(LVD_OFS_CAUSE, 8'h01);
      bus(1'b1, LVD_OFS_CTRL, 8'h00);
   endtask
   task automatic tally_and_finish;
      $display("checks=%0d mismatches=%0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Watchdog sized well past the four settling waits
   initial begin
      repeat (20000) @(posedge clk);
      mismatches++;
      tally_and_finish();
   end
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      t_defaults();
      t_irq_supply();
      t_irq_ext();
      t_reset(1'b0);
      t_reset(1'b1);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      t_defaults();
      tally_and_finish();
   end
endmodule
`default_nettype wire
